// *** rtl/tcpp_pkg.sv ***
// Shared types and constants for the Type-C charger power-policy block
package tcpp_pkg;

  // Current figures in units of 100 mA
  localparam logic [5:0] CUR_1A5    = 6'h0f;  // 1.5 A advertisement floor
  localparam logic [5:0] CUR_3A0    = 6'h1e;  // 3.0 A, receptacle ceiling
  localparam logic [5:0] CUR_5A0    = 6'h32;  // 5.0 A, captive cable ceiling
  localparam logic [5:0] CUR_ZERO   = 6'h00;  // Nothing offered

  // Hard resets that must fail before legacy signalling is allowed
  localparam logic [1:0] HR_LIMIT   = 2'h2;
  localparam logic [1:0] HR_STEP    = 2'h1;

  // Advertised Type-C current level on CC
  typedef enum logic [1:0] {
    TCPP_ADV_DEF = 2'h0,                      // Default USB power
    TCPP_ADV_1A5 = 2'h1,                      // 1.5 A
    TCPP_ADV_3A0 = 2'h2                       // 3.0 A
  } tcpp_adv_e;

  // Policy state, Gray coded along detached -> attached -> powered
  typedef enum logic [1:0] {
    TCPP_DETACHED = 2'h0,                     // No sink, VBUS off unless captive with vbus_always
    TCPP_ATTACHED = 2'h1,                     // Sink seen, VBUS ramping
    TCPP_POWERED  = 2'h3,                     // VBUS stable, PD may start
    TCPP_DEAD     = 2'h2                      // Dead battery, sink only
  } tcpp_state_e;

  // Static product configuration
  typedef struct packed {
    logic       captive;                      // Captive cable, not receptacle
    logic       vbus_always;                  // Captive: drive VBUS in any state but TCPP_DEAD
    logic       hub_dfp;                      // Port is a hub downstream port
    logic       charging_ufp;                 // Port is a charging UFP
    logic       hv_cap;                       // Can supply above default VBUS
    logic       swap_cap;                     // Can swap source and sink roles
    logic       bc12_en;                      // BC 1.2 charger present
    logic       prop_en;                      // Proprietary method present
    logic [5:0] supply_max;                   // Supply capability, 100 mA units
    logic [5:0] captive_rating;               // Captive cable rating
  } tcpp_cfg_s;

  // Status and events from the PD protocol engine
  typedef struct packed {
    logic       contract;                     // Explicit contract in place
    logic       data_dfp;                     // Current data role is DFP
    logic       hard_reset;                   // Pulse: hard reset sent
    logic       goodcrc;                      // Pulse: GoodCRC received
    logic       caps_timeout;                 // Pulse: caps got no GoodCRC
    logic       cable_id_valid;               // Discover Identity answered
    logic       cable_marked;                 // Cable is electronically marked
    logic [5:0] cable_rating;                 // Cable current capacity
    logic       vconn_good;                   // VCONN is up
  } tcpp_pd_s;

  // Registered control outputs
  typedef struct packed {
    logic       vbus_en;                      // VBUS switch enable
    logic       vconn_en;                     // VCONN switch enable
    logic       rd_both;                      // Rd on CC1 and CC2
    tcpp_adv_e  adv_level;                    // Rp current level
    logic [5:0] adv_cur;                      // Highest current offered
    logic       bfsk_sel;                     // Use legacy BFSK signalling
    logic       bfsk_hi_ok;                   // BFSK may ask above 1.5 A
    logic       drp_en;                       // Dual-role toggling allowed
    logic       alt_allow;                    // Alternate/accessory modes
    logic       sbu_connect;                  // Sideband pins connected
    logic       prop_allow;                   // Proprietary method allowed
    logic       prop_volt_allow;              // Proprietary voltage change
    logic       pd_only;                      // Contracts via PD only
    logic       drswap_accept;                // Accept data-role swap
    logic       sop_prime_allow;              // May talk to SOP'
    logic       pd_start_ok;                  // VBUS stable, PD may start
  } tcpp_ctl_s;

endpackage : tcpp_pkg

// *** rtl/tcpp_policy.sv ***
// Power-policy control for a Type-C charger port
//
// Contract
// [RL1] BFSK only after two failed hard resets
// [RL2] BFSK above 1.5 A needs VCONN, rated cable
// [RL3] Hub downstream ports never dual-role
// [RL4] Hub ports: no alt modes, SBU open
// [RL5] Source always advertises Type-C current
// [RL6] High voltage or swap: PD contracts only
// [RL7] Above 3 A: discover cable identity
// [RL8] Receptacle VBUS follows attach and detach
// [RL9] Receptacle caps at 3 A unless cable
// [RL10] Captive cable may drive VBUS anytime
// [RL11] Captive advertises cable rating, max 5 A
// [RL12] Proprietary method sets current only
// [RL13] Sink proprietary never redefines voltage
// [RL14] Charging UFP: PD and DR_Swap accepted
// [RL15] Dead battery: Rd both pins, UFP
// [RL16] Charged dead-battery system may request DR_Swap
// [RL17] Marked cable answers SOP' identity
// [RL18] SOP' limited to DFP after contract
// [RL19] Unpowered cable never disturbs CC
// [RL20] Contract means 1.5 A or 3 A advertised
// [RL21] BC 1.2 at 1.5 A advertises 1.5 A
// [RL22] Proprietary 3 A source advertises 3 A
// [RL23] VBUS switched from debounced inputs only
`timescale 1ns/1ps

module tcpp_policy (
  input  wire logic              mclk,             // 40 MHz system clock
  input  wire logic              rst_b,            // Async reset, active low
  input  wire tcpp_pkg::tcpp_cfg_s cfg,            // Product configuration
  input  wire tcpp_pkg::tcpp_pd_s  pd,             // PD engine status
  input  wire logic              sink_attached,    // Debounced sink attach
  input  wire logic              sink_open,        // Debounced detach
  input  wire logic              vbus_good,        // VBUS within range
  input  wire logic              dead_batt,        // Battery is dead
  input  wire logic              charge_ok,        // Battery charged enough
  input  wire logic [5:0]        bfsk_want,        // Current BFSK would ask
  output tcpp_pkg::tcpp_ctl_s    ctl,              // Registered controls
  output logic                   disc_id_req,      // Pulse: query cable
  output logic                   drswap_req        // Pulse: request DR_Swap
);

  // Policy state and its next value
  tcpp_pkg::tcpp_state_e state_r;
  tcpp_pkg::tcpp_state_e state_nxt;
  logic [1:0]            hr_cnt_r;         // Failed hard resets seen
  logic                  bfsk_r;           // Legacy signalling selected
  logic                  disc_done_r;      // Identity already queried
  logic                  was_dead_r;       // Came up from dead battery
  logic                  charge_ok_d_r;    // Previous charge_ok
  logic                  disc_req_r;       // Registered query pulse
  logic                  drswap_req_r;     // Registered swap pulse
  tcpp_pkg::tcpp_ctl_s   ctl_r;            // Output register
  tcpp_pkg::tcpp_ctl_s   ctl_nxt;          // Output next value
  logic [5:0]            cap_cur;          // Current ceiling now allowed
  logic                  detach_seen;      // Sink gone or never there

  // Smaller of two current figures
  function automatic logic [5:0] cur_min(input logic [5:0] a, input logic [5:0] b);
    cur_min = (a < b) ? a : b;
  endfunction : cur_min

  // Rp level for a current ceiling; a contract forbids the default level
  function automatic tcpp_pkg::tcpp_adv_e adv_of(input logic [5:0] cur,
                                                 input logic       in_contract);
    if (cur >= tcpp_pkg::CUR_3A0) begin
      adv_of = tcpp_pkg::TCPP_ADV_3A0;               // RL22
    end else if (cur >= tcpp_pkg::CUR_1A5 || in_contract) begin
      adv_of = tcpp_pkg::TCPP_ADV_1A5;               // RL20
    end else begin
      adv_of = tcpp_pkg::TCPP_ADV_DEF;               // RL21
    end
  endfunction : adv_of

  // Detach is the debounced open level, or no attach at all
  assign detach_seen = sink_open | ~sink_attached;

  // Next policy state, driven by debounced CC levels, vbus_good and dead_batt
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      tcpp_pkg::TCPP_DETACHED: begin
        if (dead_batt) begin
          state_nxt = tcpp_pkg::TCPP_DEAD;           // RL15
        end else if (sink_attached && !sink_open) begin
          state_nxt = tcpp_pkg::TCPP_ATTACHED;       // RL23
        end
      end
      tcpp_pkg::TCPP_ATTACHED: begin
        if (dead_batt) begin
          state_nxt = tcpp_pkg::TCPP_DEAD;
        end else if (detach_seen) begin
          state_nxt = tcpp_pkg::TCPP_DETACHED;       // RL8
        end else if (vbus_good) begin
          state_nxt = tcpp_pkg::TCPP_POWERED;
        end
      end
      tcpp_pkg::TCPP_POWERED: begin
        if (dead_batt) begin
          state_nxt = tcpp_pkg::TCPP_DEAD;
        end else if (detach_seen) begin
          state_nxt = tcpp_pkg::TCPP_DETACHED;       // RL8
        end
      end
      tcpp_pkg::TCPP_DEAD: begin
        // Stay a sink until the battery can carry the system
        if (!dead_batt) begin
          state_nxt = tcpp_pkg::TCPP_DETACHED;
        end
      end
      default: begin
        state_nxt = tcpp_pkg::TCPP_DETACHED;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= tcpp_pkg::TCPP_DETACHED;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Local copy so the comparison width is explicit
  localparam logic [1:0] HR_LIMIT_L = tcpp_pkg::HR_LIMIT;

  // Hard reset tally; any GoodCRC proves BMC works and restarts it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hr_cnt_r <= 2'h0;
    end else if (state_r == tcpp_pkg::TCPP_DETACHED || pd.goodcrc) begin
      hr_cnt_r <= 2'h0;
    end else if (pd.hard_reset && hr_cnt_r < HR_LIMIT_L) begin
      hr_cnt_r <= hr_cnt_r + tcpp_pkg::HR_STEP;      // RL1
    end
  end

  // Legacy BFSK selection; set wins over the detach clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bfsk_r <= 1'b0;
    end else if (pd.caps_timeout && hr_cnt_r >= HR_LIMIT_L) begin
      bfsk_r <= 1'b1;                                // RL1
    end else if (state_r == tcpp_pkg::TCPP_DETACHED) begin
      bfsk_r <= 1'b0;
    end
  end

  // Cable identity query, once per attach, only for supplies above 3 A
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      disc_done_r <= 1'b0;
      disc_req_r  <= 1'b0;
    end else begin
      disc_req_r <= 1'b0;
      if (state_r == tcpp_pkg::TCPP_DETACHED) begin
        disc_done_r <= 1'b0;
      end else if (state_r == tcpp_pkg::TCPP_POWERED && !disc_done_r &&
                   cfg.supply_max > tcpp_pkg::CUR_3A0 && ctl_r.sop_prime_allow) begin
        disc_req_r  <= 1'b1;                         // RL7
        disc_done_r <= 1'b1;
      end
    end
  end

  // Remember a dead-battery start and ask for the DFP role once charged
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      was_dead_r    <= 1'b0;
      charge_ok_d_r <= 1'b0;
      drswap_req_r  <= 1'b0;
    end else begin
      charge_ok_d_r <= charge_ok;
      drswap_req_r  <= 1'b0;
      if (state_r == tcpp_pkg::TCPP_DEAD) begin
        was_dead_r <= 1'b1;
      end else if (was_dead_r && charge_ok && !charge_ok_d_r && pd.contract) begin
        drswap_req_r <= 1'b1;                        // RL16
        was_dead_r   <= 1'b0;
      end
    end
  end

  // Current ceiling: captive cable rating, else 3 A until the cable is known
  always_comb begin
    if (cfg.captive) begin
      cap_cur = cur_min(cur_min(cfg.captive_rating, tcpp_pkg::CUR_5A0),
                        cfg.supply_max);             // RL11
    end else if (pd.cable_id_valid) begin
      cap_cur = cur_min(pd.cable_rating, cfg.supply_max);  // RL9
    end else begin
      cap_cur = cur_min(cfg.supply_max, tcpp_pkg::CUR_3A0); // RL9
    end
  end

  // Output decisions for the next cycle
  always_comb begin
    ctl_nxt = '0;
    // VBUS: receptacle follows attach; captive may run it freely
    ctl_nxt.vbus_en = (state_r == tcpp_pkg::TCPP_ATTACHED ||
                       state_r == tcpp_pkg::TCPP_POWERED) && !detach_seen; // RL8 RL23
    if (cfg.captive && cfg.vbus_always && state_r != tcpp_pkg::TCPP_DEAD) begin
      ctl_nxt.vbus_en = 1'b1;                        // RL10
    end
    // Dead battery presents Rd on both pins and sources nothing
    ctl_nxt.rd_both = (state_r == tcpp_pkg::TCPP_DEAD); // RL15
    // VCONN once powered, so the cable can be queried or checked
    ctl_nxt.vconn_en = (state_r == tcpp_pkg::TCPP_POWERED); // RL2
    // Rp level always present on a source; PD contract keeps it non-default
    if (ctl_nxt.vbus_en) begin
      ctl_nxt.adv_level = adv_of(cap_cur, pd.contract); // RL5 RL20
      ctl_nxt.adv_cur   = cap_cur;
    end else begin
      ctl_nxt.adv_level = tcpp_pkg::TCPP_ADV_DEF;
      ctl_nxt.adv_cur   = tcpp_pkg::CUR_ZERO;
    end
    // BC 1.2 below 1.5 A stays at default while no contract is in place
    if (cfg.bc12_en && !pd.contract && cap_cur < tcpp_pkg::CUR_1A5) begin
      ctl_nxt.adv_level = tcpp_pkg::TCPP_ADV_DEF;    // RL21
    end
    // Legacy signalling and its high-current gate
    ctl_nxt.bfsk_sel   = bfsk_r;                     // RL1
    ctl_nxt.bfsk_hi_ok = bfsk_r && pd.vconn_good && pd.cable_marked &&
                         pd.cable_id_valid && pd.cable_rating >= bfsk_want; // RL2
    // Hub downstream ports: fixed source and host, no modes, SBU open
    ctl_nxt.drp_en      = !cfg.hub_dfp && (cfg.charging_ufp || cfg.swap_cap); // RL3
    ctl_nxt.alt_allow   = !cfg.hub_dfp;              // RL4
    ctl_nxt.sbu_connect = !cfg.hub_dfp;              // RL4
    // High voltage or role swapping forces PD-only contracts
    ctl_nxt.pd_only    = cfg.hv_cap || cfg.swap_cap || cfg.charging_ufp; // RL6 RL14
    ctl_nxt.prop_allow = cfg.prop_en && !ctl_nxt.pd_only && !pd.contract; // RL6 RL12
    // Proprietary methods never alter voltage, on source or sink side
    ctl_nxt.prop_volt_allow = 1'b0;                  // RL12 RL13
    ctl_nxt.drswap_accept   = cfg.charging_ufp;      // RL14
    // SOP' open to a charging UFP only before a contract
    ctl_nxt.sop_prime_allow = pd.data_dfp ||
                              (cfg.charging_ufp && !pd.contract); // RL18
    // PD waits for stable VBUS; an unpowered cable is not queried
    ctl_nxt.pd_start_ok = (state_r == tcpp_pkg::TCPP_POWERED) && vbus_good; // RL19
  end

  // Output register, so every control is glitch free
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_r <= '0;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  assign ctl         = ctl_r;
  assign disc_id_req = disc_req_r;                   // RL17 answer awaited via pd
  assign drswap_req  = drswap_req_r;

endmodule : tcpp_policy

// *** tb/tcpp_policy_monitor.sv ***
// Concurrent assertion checker for the charger power-policy block
`timescale 1ns/1ps

module tcpp_policy_monitor (
  input wire logic                mclk,          // System clock
  input wire logic                rst_b,         // Async reset, active low
  input wire tcpp_pkg::tcpp_cfg_s cfg,           // Product configuration
  input wire tcpp_pkg::tcpp_pd_s  pd,            // PD engine status
  input wire logic                sink_open,     // Debounced detach
  input wire logic                sink_attached, // Debounced attach
  input wire logic                dead_batt,     // Battery dead
  input wire tcpp_pkg::tcpp_ctl_s ctl,           // Controls under watch
  input wire logic                disc_id_req,   // Cable query pulse
  input wire logic                drswap_req     // Swap request pulse
);
  // One domain, so one clock and one reset serve every property
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_vbus_off_open: assert property (sink_open && !cfg.captive |=> !ctl.vbus_en)
    else $error("VBUS still on one cycle after detach");
  a_vbus_from_attach: assert property ($rose(ctl.vbus_en) && !cfg.vbus_always |-> $past(sink_attached, 2))
    else $error("VBUS rose without a debounced attach");
  a_hub_port_plain: assert property (cfg.hub_dfp |=> !ctl.drp_en && !ctl.alt_allow && !ctl.sbu_connect)
    else $error("Hub port shows dual-role, mode or sideband");
  a_contract_level: assert property (pd.contract && $past(pd.contract) && ctl.vbus_en && !cfg.captive
                                     |-> ctl.adv_level != tcpp_pkg::TCPP_ADV_DEF)
    else $error("Default level advertised under a contract");
  a_rcpt_cap_3a: assert property (!cfg.captive && !pd.cable_id_valid |=> ctl.adv_cur <= tcpp_pkg::CUR_3A0)
    else $error("Receptacle offers above 3 A without cable data");
  a_captive_cap: assert property (cfg.captive |=> ctl.adv_cur <= tcpp_pkg::CUR_5A0
                                  && ctl.adv_cur <= $past(cfg.captive_rating))
    else $error("Captive advertisement above cable rating");
  a_no_volt_change: assert property (!ctl.prop_volt_allow)
    else $error("Proprietary voltage change allowed");
  a_pd_only_set: assert property (cfg.hv_cap || cfg.swap_cap || cfg.charging_ufp |=> ctl.pd_only)
    else $error("Contracts not restricted to PD");
  a_bfsk_after_fail: assert property ($rose(ctl.bfsk_sel) |-> $past(pd.caps_timeout, 2))
    else $error("Legacy signalling chosen without a failed caps");
  a_bfsk_hi_gate: assert property (ctl.bfsk_hi_ok |-> $past(pd.vconn_good && pd.cable_marked))
    else $error("High BFSK current without VCONN and marked cable");
  a_dead_rd_both: assert property (dead_batt [*2] |=> ctl.rd_both && !ctl.vbus_en)
    else $error("Dead battery without sink pull-downs");
  a_sop_dfp_only: assert property (pd.contract && !pd.data_dfp |=> !ctl.sop_prime_allow)
    else $error("SOP prime open to a UFP under contract");

  // Main scenarios reached
  c_bfsk: cover property ($rose(ctl.bfsk_sel));
  c_query: cover property (disc_id_req);
  c_swap: cover property (drswap_req);
  c_dead: cover property (ctl.rd_both);
endmodule : tcpp_policy_monitor

bind tcpp_policy tcpp_policy_monitor i_mon (.mclk(mclk), .rst_b(rst_b), .cfg(cfg), .pd(pd),
  .sink_open(sink_open), .sink_attached(sink_attached), .dead_batt(dead_batt), .ctl(ctl),
  .disc_id_req(disc_id_req), .drswap_req(drswap_req));

// *** tb/tcpp_cable_model.sv ***
// Behavioural marked cable that answers identity queries
`timescale 1ns/1ps

module tcpp_cable_model #(
  parameter int         LAT    = 6,       // Cycles to answer a query
  parameter logic [5:0] RATING = 6'h32    // Reported current capacity
) (
  input  wire logic       mclk,            // System clock
  input  wire logic       rst_b,           // Async reset, active low
  input  wire logic       query,           // Identity request pulse
  input  wire logic       vconn,           // VCONN applied to the cable
  output logic            id_valid,        // Identity answer held
  output logic            marked,          // Cable is marked
  output logic [5:0]      rating           // Current capacity
);
  int cnt_r;  // Answer countdown, 0 when idle

  // Unpowered, a query is ignored so CC traffic is left alone
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 0;
      id_valid <= 1'b0;
      marked <= 1'b0;
      rating <= 6'h15;
    end else begin
      if (query && vconn && !id_valid) begin
        cnt_r <= LAT;
      end else if (cnt_r > 1) begin
        cnt_r <= cnt_r - 1;
      end else if (cnt_r == 1) begin
        cnt_r <= 0;
        id_valid <= 1'b1;
        marked <= 1'b1;
      end
      // Toggle until answered; the true rating lands with the answer itself
      rating <= (id_valid || cnt_r == 1) ? RATING : ~rating;
    end
  end
endmodule : tcpp_cable_model

// *** tb/test_tcpp_policy.sv ***
// Self-checking bench for the charger power-policy block
`timescale 1ns/1ps

module test_tcpp_policy;
  logic                mclk, rst_b;                  // Clock, reset
  tcpp_pkg::tcpp_cfg_s cfg;                          // Configuration
  tcpp_pkg::tcpp_pd_s  pd_r, pd;                     // Driven and merged PD status
  logic                sink_attached, sink_open;     // Debounced attach, detach
  logic                vbus_good, dead_batt, charge_ok; // Supply and battery
  logic [5:0]          bfsk_want, rnd, cr, opt;      // BFSK ask, random, rating, options
  logic [7:0]          want8;                        // Expected hub controls
  tcpp_pkg::tcpp_ctl_s ctl;                          // Controls out
  logic                disc_id_req, drswap_req, cv, cm; // Pulses, cable flags
  logic [4:0]          exp_q[$];                     // Expected event vectors
  logic [4:0]          obs, prev;                    // Watched outputs
  int                  bad_count = 0, check_count = 0, seed = 10, i;
  int                  seq_a[5] = '{0, 1, 0, 2, 3};  // Reset, ack, reset, timeout
  int                  seq_b[3] = '{0, 2, 3};        // Second reset, timeout

  assign obs = {ctl.vbus_en, ctl.bfsk_sel, ctl.rd_both, drswap_req, disc_id_req};
  // Cable answers replace the bench's own cable fields
  always_comb begin
    pd = pd_r;
    pd.cable_id_valid = cv;
    pd.cable_marked = cm;
    pd.cable_rating = cr;
  end

  tcpp_policy i_dut (.mclk(mclk), .rst_b(rst_b), .cfg(cfg), .pd(pd),
    .sink_attached(sink_attached), .sink_open(sink_open), .vbus_good(vbus_good),
    .dead_batt(dead_batt), .charge_ok(charge_ok), .bfsk_want(bfsk_want), .ctl(ctl),
    .disc_id_req(disc_id_req), .drswap_req(drswap_req));
  tcpp_cable_model i_cable (.mclk(mclk), .rst_b(rst_b), .query(disc_id_req),
    .vconn(ctl.vconn_en), .id_valid(cv), .marked(cm), .rating(cr));

  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  // One PD event pulse: 0 hard reset, 1 GoodCRC, 2 caps timeout, 3 none
  task automatic pulse(input int which);
    @(posedge mclk);
    pd_r.hard_reset <= (which == 0);
    pd_r.goodcrc <= (which == 1);
    pd_r.caps_timeout <= (which == 2);
  endtask : pulse

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // Every change of the watched outputs must match the oldest note
  always @(posedge mclk) begin
    #2;
    if (rst_b === 1'b1 && obs !== prev) begin
      if (exp_q.size() == 0) check({3'h0, obs}, {3'h0, prev});
      else check({3'h0, obs}, {3'h0, exp_q.pop_front()});
    end
    prev = obs;
  end

  // Hang guard, far beyond the roughly one hundred cycles of the sequence
  initial begin
    tick(4000);
    bad_count++;
    end_of_test();
  end

  initial begin
    rst_b = 1'b0;
    cfg = '0;
    pd_r = '0;
    {sink_attached, vbus_good, dead_batt, charge_ok} = 4'h0;
    sink_open = 1'b1;
    bfsk_want = 6'h14;
    cfg.supply_max = tcpp_pkg::CUR_5A0;
    cfg.hv_cap = 1'b1;
    pd_r.data_dfp = 1'b1;
    pd_r.vconn_good = 1'b1;
    tick(10);
    rst_b <= 1'b1;
    tick(2);
    // Attach: VBUS on, then one cable query above 3 A
    exp_q = '{5'h10, 5'h11, 5'h10};
    sink_attached <= 1'b1;
    sink_open <= 1'b0;
    vbus_good <= 1'b1;
    tick(3);
    check({2'h0, ctl.adv_cur}, {2'h0, tcpp_pkg::CUR_3A0});
    check({6'h0, ctl.vconn_en, ctl.pd_start_ok}, 8'h03);
    tick(16);
    check({2'h0, ctl.adv_cur}, {2'h0, tcpp_pkg::CUR_5A0});
    check({6'h0, ctl.adv_level}, {6'h0, tcpp_pkg::TCPP_ADV_3A0});
    // Contract held by a UFP data role
    pd_r.contract <= 1'b1;
    pd_r.data_dfp <= 1'b0;
    tick(3);
    check({7'h0, ctl.sop_prime_allow}, 8'h00);
    // A GoodCRC restarts the hard reset count
    foreach (seq_a[i]) pulse(seq_a[i]);
    tick(4);
    exp_q.push_back(5'h18);
    foreach (seq_b[i]) pulse(seq_b[i]);
    tick(4);
    check({7'h0, ctl.bfsk_hi_ok}, 8'h01);
    bfsk_want <= 6'h3f;
    tick(3);
    check({7'h0, ctl.bfsk_hi_ok}, 8'h00);
    // Captive cable with random ratings and product options
    for (i = 0; i < 8; i++) begin
      rnd = 6'($random(seed));
      cfg.captive <= 1'b1;
      cfg.captive_rating <= rnd;
      opt = 6'($random(seed));
      {cfg.hub_dfp, cfg.swap_cap, cfg.bc12_en, cfg.prop_en, cfg.charging_ufp,
       cfg.vbus_always} <= opt;
      tick(3);
      check({2'h0, ctl.adv_cur}, {2'h0, (rnd < tcpp_pkg::CUR_5A0) ? rnd : tcpp_pkg::CUR_5A0});
      // Hub port: no dual role, no modes, sideband open
      want8 = {5'h0, ~opt[5] & (opt[4] | opt[1]), ~opt[5], ~opt[5]};
      check({5'h0, ctl.drp_en, ctl.alt_allow, ctl.sbu_connect}, want8);
      check({7'h0, ctl.drswap_accept}, {7'h0, opt[1]});
    end
    {cfg.captive, cfg.hub_dfp, cfg.swap_cap, cfg.bc12_en, cfg.prop_en, cfg.charging_ufp,
     cfg.vbus_always} <= 7'h00;
    // Detach drops VBUS first, then the legacy select
    exp_q = '{5'h08, 5'h00};
    sink_attached <= 1'b0;
    sink_open <= 1'b1;
    tick(6);
    // Dead battery refuses an attach
    exp_q = '{5'h04, 5'h00, 5'h02, 5'h00};
    dead_batt <= 1'b1;
    tick(4);
    sink_attached <= 1'b1;
    sink_open <= 1'b0;
    tick(4);
    sink_attached <= 1'b0;
    sink_open <= 1'b1;
    tick(2);
    dead_batt <= 1'b0;
    tick(4);
    charge_ok <= 1'b1;
    tick(4);
    check(8'(exp_q.size()), 8'h00);
    end_of_test();
  end
endmodule : test_tcpp_policy
